// [core/spi_cfg_pkg.sv]
package spi_cfg_pkg;
    localparam int          SYS_CLK_HZ    = 250_000_000;
    localparam int          SCK_MAX_HZ    = 200_000;
    // least half period, rounded up so the bus clock never exceeds its ceiling
    localparam int          SCK_HALF_MIN  = (SYS_CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
    localparam int          DIV_W         = 16;
    localparam int          XFER_BITS     = 8;
    localparam int          XFER_EDGES    = 2 * XFER_BITS;
    localparam int          EDGE_CNT_W    = 5;
    localparam int          SYNC_STAGES   = 2;
    localparam int          BUF_DEPTH     = 2;
    localparam logic [7:0]  TX_RESET      = 8'h00;
    localparam logic [7:0]  RX_RESET      = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_SHIFT = 3'b010,
        ST_HOLD  = 3'b011,
        ST_PUSH  = 3'b100
    } xfer_state_t;
endpackage : spi_cfg_pkg

// [core/bit_sync.sv]
`timescale 1ns/100ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    // first stage feeds only the second
    logic [WIDTH-1:0] meta;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule : bit_sync

// [core/pair_buffer.sv]
`timescale 1ns/100ps
module pair_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] fill;

    wire push = in_valid_i && in_ready_o;
    wire pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (fill != CNT_W'(DEPTH));

    wire [PTR_W-1:0] wr_inc = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    wire [PTR_W-1:0] rd_inc = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

    // head is registered so the reader sees flops only; a word landing
    // in the slot that becomes head is taken straight from the input
    wire [PTR_W-1:0] next_rd   = pop ? rd_inc : rd_ptr;
    wire [CNT_W-1:0] next_fill = (push && !pop) ? fill + 1'b1 :
                                 (pop && !push) ? fill - 1'b1 : fill;
    wire [WIDTH-1:0] next_head = (push && wr_ptr == next_rd) ? in_data_i : mem[next_rd];

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            fill        <= '0;
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else begin
            if (push) wr_ptr <= wr_inc;
            rd_ptr      <= next_rd;
            fill        <= next_fill;
            out_valid_o <= (next_fill != '0);
            out_data_o  <= next_head;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (push) mem[wr_ptr] <= in_data_i;
    end
endmodule : pair_buffer

// [core/spi_master_engine.sv]
`timescale 1ns/100ps
// Summary of operation
// - bus clock divided from mclk, half period clamped so it never passes 200 kHz
// - software picks a divider no faster than the attached peripheral allows
// - clock polarity input sets the idle level of the serial clock
// - phase zero: first clock edge samples first bit at both ends
// - phase zero: first edge a whole bit after start, data already presented
// - phase one: first edge half a bit after start drives data, next edge samples
// - polarity and phase must match the selected peripheral
// - polarity, phase and select settings latched per transfer, free to change between
// - chip select generation enabled only by its enable input
// - select index chooses which general pin carries chip select
// - at most one chip select line is active at a time, except that reset and the cycle after it drive every line high
// - select polarity input sets active level, held for the whole transfer
// - active low: select falls before transfer, rises after last data
// - active high: select rises before transfer, falls after last data
// - active high mode serves three-wire peripherals with high-true select
module spi_master_engine
    import spi_cfg_pkg::*;
#(
    parameter int NUM_CS = 4,
    parameter int CS_W   = (NUM_CS > 1) ? $clog2(NUM_CS) : 1
) (
    input  wire logic              mclk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [DIV_W-1:0]  half_div_i,
    input  wire logic              cpol_i,
    input  wire logic              cpha_i,
    input  wire logic              cs_en_i,
    input  wire logic [CS_W-1:0]   cs_sel_i,
    input  wire logic              cs_active_high_i,
    input  wire logic              tx_valid_i,
    output logic                   tx_ready_o,
    input  wire logic [7:0]        tx_data_i,
    output logic                   rx_valid_o,
    input  wire logic              rx_ready_i,
    output logic      [7:0]        rx_data_o,
    output logic                   busy_o,
    output logic                   sck_o,
    output logic                   mosi_o,
    input  wire logic              miso_i,
    output logic      [NUM_CS-1:0] cs_o
);
    localparam logic [DIV_W-1:0]      HALF_MIN  = DIV_W'(SCK_HALF_MIN);
    localparam logic [EDGE_CNT_W-1:0] EDGES_END = EDGE_CNT_W'(XFER_EDGES);

    xfer_state_t             state;
    xfer_state_t             next_state;
    logic [DIV_W-1:0]        half_len;
    logic [DIV_W-1:0]        cnt;
    logic [EDGE_CNT_W-1:0]   edge_cnt;
    logic                    cpol_l;
    logic                    cpha_l;
    logic                    cs_en_l;
    logic [CS_W-1:0]         cs_sel_l;
    logic                    cs_hi_l;
    logic [7:0]              tx_sh;
    logic [7:0]              rx_sh;
    logic                    push;
    logic                    miso_s;
    logic                    buf_in_ready;

    bit_sync #(
        .WIDTH (1)
    ) u_miso_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (miso_i),
        .sync_o    (miso_s)
    );

    // a stalled reader holds the engine idle, so no received byte is dropped
    pair_buffer #(
        .WIDTH (8),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buf (
        .mclk_i      (mclk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (push),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (rx_sh),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  (rx_data_o)
    );

    wire accept    = (state == ST_IDLE) && tx_valid_i && tx_ready_o;
    wire [DIV_W-1:0] div_clamped = (half_div_i < HALF_MIN) ? HALF_MIN : half_div_i;
    wire half_tick = (cnt == half_len - 1'b1);
    // phase one fires its first edge with no lead-in
    wire first_now = cpha_l && (edge_cnt == '0) && (cnt == '0);
    wire edges_done = (edge_cnt == EDGES_END);
    wire edge_now  = (state == ST_SHIFT) && !edges_done && (half_tick || first_now);
    wire leading   = !edge_cnt[0];
    // phase zero samples on leading edges, phase one on trailing
    wire sample_edge = edge_now && (cpha_l ? !leading : leading);
    // phase zero drives on trailing edges except the last one
    wire drive_edge  = edge_now && (cpha_l ? leading :
                       (!leading && edge_cnt != EDGES_END - 1'b1));
    wire cs_assert   = (state == ST_SETUP) || (state == ST_SHIFT) || (state == ST_HOLD);
    wire [NUM_CS-1:0] one_hot = NUM_CS'(1) << cs_sel_l;
    wire [NUM_CS-1:0] active_mask = (cs_en_l && cs_assert) ? one_hot : '0;
    wire [NUM_CS-1:0] next_cs = cs_hi_l ? active_mask : ~active_mask;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept) next_state = ST_SETUP;
            end
            ST_SETUP: begin
                if (half_tick) next_state = ST_SHIFT;
            end
            ST_SHIFT: begin
                // phase zero ends on its last edge, phase one waits a further half bit
                if (edges_done && (!cpha_l || half_tick)) next_state = ST_HOLD;
                else if (edge_now && !cpha_l && edge_cnt == EDGES_END - 1'b1)
                    next_state = ST_HOLD;
            end
            ST_HOLD: begin
                if (half_tick) next_state = ST_PUSH;
            end
            ST_PUSH: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) state <= ST_IDLE;
        else           state <= next_state;
    end

    // half period counter, restarted on every state change and every edge
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i)                                 cnt <= '0;
        else if (next_state != state || edge_now || half_tick) cnt <= '0;
        else                                           cnt <= cnt + 1'b1;
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i)     edge_cnt <= '0;
        else if (accept)   edge_cnt <= '0;
        else if (edge_now) edge_cnt <= edge_cnt + 1'b1;
    end

    // settings taken once per transfer, idle settings track inputs
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            half_len <= HALF_MIN;
            cpol_l   <= 1'b0;
            cpha_l   <= 1'b0;
            cs_en_l  <= 1'b0;
            cs_sel_l <= '0;
            cs_hi_l  <= 1'b0;
        end else if (state == ST_IDLE) begin
            half_len <= div_clamped;
            cpol_l   <= cpol_i;
            cpha_l   <= cpha_i;
            cs_en_l  <= cs_en_i;
            cs_sel_l <= cs_sel_i;
            cs_hi_l  <= cs_active_high_i;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i)              sck_o <= 1'b0;
        else if (state == ST_IDLE)  sck_o <= cpol_i;
        else if (edge_now)          sck_o <= !sck_o;
    end

    // msb first; phase zero presents bit 7 before any edge
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_sh  <= TX_RESET;
            mosi_o <= 1'b0;
        end else if (accept) begin
            if (!cpha_i) begin
                mosi_o <= tx_data_i[7];
                tx_sh  <= {tx_data_i[6:0], 1'b0};
            end else begin
                tx_sh  <= tx_data_i;
            end
        end else if (drive_edge) begin
            mosi_o <= tx_sh[7];
            tx_sh  <= {tx_sh[6:0], 1'b0};
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i)        rx_sh <= RX_RESET;
        else if (sample_edge) rx_sh <= {rx_sh[6:0], miso_s};
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) cs_o <= '1;
        else           cs_o <= next_cs;
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            push       <= 1'b0;
            tx_ready_o <= 1'b0;
            busy_o     <= 1'b0;
        end else begin
            push       <= (next_state == ST_PUSH);
            // room only shrinks through our own push, so a stale ready is safe
            tx_ready_o <= (next_state == ST_IDLE) && buf_in_ready && !push;
            busy_o     <= (next_state != ST_IDLE);
        end
    end

endmodule : spi_master_engine

// [test/spi_master_engine_chk.sv]
`timescale 1ns/100ps
module spi_master_engine_chk
    import spi_cfg_pkg::*;
#(
    parameter int NUM_CS = 4,
    parameter int CS_W   = 2
) (
    input wire logic              mclk_i,
    input wire logic              sys_rst_i,
    input wire logic              cpol_i,
    input wire logic              cpha_i,
    input wire logic              cs_en_i,
    input wire logic [CS_W-1:0]   cs_sel_i,
    input wire logic              cs_active_high_i,
    input wire logic              tx_ready_o,
    input wire logic              rx_valid_o,
    input wire logic              busy_o,
    input wire logic              sck_o,
    input wire logic              mosi_o,
    input wire logic [NUM_CS-1:0] cs_o
);
    int               hcnt;
    int               bcnt;
    logic [4:0]       ecnt;
    logic             sck_q;
    wire              sck_edge = sck_o != sck_q;
    wire [NUM_CS-1:0] cs_idle = {NUM_CS{~cs_active_high_i}};
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {hcnt, ecnt, sck_q} <= '0;
            bcnt <= 0;
        end else begin
            hcnt <= sck_edge ? 0 : hcnt + 1;
            bcnt <= busy_o ? bcnt + 1 : 0;
            ecnt <= busy_o ? ecnt + 5'(sck_edge) : 5'h00;
            sck_q <= sck_o;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_start; $rose(busy_o); endsequence
    sequence s_end; $fell(busy_o); endsequence
    a_sck_idle: assert property (
        tx_ready_o && $past(tx_ready_o) |-> sck_o == $past(cpol_i)) else $error("sck not idle");
    a_mosi_hold: assert property (
        tx_ready_o && $past(tx_ready_o) |-> $stable(mosi_o)) else $error("mosi moved in idle");
    a_half_min: assert property (
        sck_edge && busy_o |-> hcnt >= SCK_HALF_MIN - 1) else $error("sck half period short");
    a_edge_count: assert property (
        s_end |-> ecnt == 5'(XFER_EDGES)) else $error("wrong sck edge count");
    a_lead_time: assert property (
        s_start |-> $stable(sck_o)[*8]) else $error("sck edge too soon after start");
    a_one_sel: assert property (
        busy_o |-> $onehot0(cs_o ^ cs_idle)) else $error("several selects active");
    a_sel_start: assert property (s_start |-> ##1 cs_o == (cs_idle ^
        ({NUM_CS{$past(cs_en_i, 2)}} & (NUM_CS'(1) << $past(cs_sel_i, 2)))))
        else $error("bad select");
    a_first_edge: assert property (
        sck_edge && busy_o && ecnt == 5'h00 |->
        (cpha_i ? bcnt < 2 * SCK_HALF_MIN : bcnt >= 2 * SCK_HALF_MIN))
        else $error("first sck edge at wrong time");
    a_rx_push: assert property (
        s_end |-> ##[0:1] rx_valid_o) else $error("no byte after transfer");
endmodule : spi_master_engine_chk

// [test/spi_slave_model.sv]
`timescale 1ns/100ps
module spi_slave_model (
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       sel_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    input  wire logic [7:0] tx_i,
    output logic            miso_o,
    output logic      [7:0] rx_o
);
    logic [7:0] shreg;
    initial {miso_o, rx_o, shreg} = 17'h00000;
    // no pull on the line: flip on release so a stale bit never reads as valid
    always @(sel_i) begin
        if (sel_i) begin
            shreg = tx_i;
            if (!cpha_i) miso_o = shreg[7];
        end else begin
            miso_o = ~miso_o;
        end
    end
    always @(sck_i) begin
        if (sel_i && ((sck_i != cpol_i) ^ cpha_i)) begin
            rx_o = {rx_o[6:0], mosi_i};
        end else if (sel_i) begin
            if (!cpha_i) shreg = {shreg[6:0], 1'b0};
            miso_o = shreg[7];
            if (cpha_i) shreg = {shreg[6:0], 1'b0};
        end
    end
endmodule : spi_slave_model

// [test/spi_master_config_engine_tb.sv]
`timescale 1ns/100ps
module spi_master_config_engine_tb;
    import spi_cfg_pkg::*;
    localparam int NUM_CS = 4;
    localparam int CS_W   = 2;
    logic mclk_i = 0, sys_rst_i = 1, tx_valid_i = 0, rx_ready_i = 0;
    logic cpol_i = 0, cpha_i = 0, cs_en_i = 0, cs_active_high_i = 0;
    logic tx_ready_o, rx_valid_o, busy_o, sck_o, mosi_o, miso_i;
    logic [DIV_W-1:0]  half_div_i = 16'h0001;
    logic [CS_W-1:0]   cs_sel_i = 2'h0;
    logic [7:0]        tx_data_i = 8'h00, slv_tx = 8'h00, rx_data_o, slv_rx;
    logic [NUM_CS-1:0] cs_o;
    wire  [NUM_CS-1:0] cs_idle = {NUM_CS{~cs_active_high_i}};
    int                bad_count = 0, num_checks = 0;
    always #2 mclk_i = ~mclk_i;
    spi_master_engine #(.NUM_CS(NUM_CS), .CS_W(CS_W)) dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .half_div_i(half_div_i),
        .cpol_i(cpol_i), .cpha_i(cpha_i), .cs_en_i(cs_en_i), .cs_sel_i(cs_sel_i),
        .cs_active_high_i(cs_active_high_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i), .rx_valid_o(rx_valid_o),
        .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o), .busy_o(busy_o),
        .sck_o(sck_o), .mosi_o(mosi_o), .miso_i(miso_i), .cs_o(cs_o));
    spi_slave_model slv (.sck_i(sck_o), .mosi_i(mosi_o), .cpol_i(cpol_i), .cpha_i(cpha_i),
        .sel_i(cs_o[cs_sel_i] === cs_active_high_i), .tx_i(slv_tx), .miso_o(miso_i), .rx_o(slv_rx));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic send(input logic [7:0] b);
        tx_data_i = b;
        tx_valid_i = 1;
        for (int n = 0; n < 30000 && tx_ready_o !== 1'b1; n++) @(negedge mclk_i);
        if (tx_ready_o !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: send timed out", $time);
        end
        @(negedge mclk_i);
        tx_valid_i = 0;
    endtask : send
    task automatic take(output logic [7:0] d);
        for (int n = 0; n < 15000 && rx_valid_o !== 1'b1; n++) @(negedge mclk_i);
        d = (rx_valid_o === 1'b1) ? rx_data_o : 8'hxx;
        rx_ready_i = 1;
        @(negedge mclk_i);
        rx_ready_i = 0;
    endtask : take
    // half_div of 1 is raised to the 625-cycle half period floor (200 kHz ceiling), which keeps runs long
    task automatic t_modes();
        logic [7:0] d;
        for (int m = 0; m < 4; m++) begin
            {cpol_i, cpha_i, cs_sel_i, cs_en_i, cs_active_high_i} = {m[1:0], 2'(m), 1'b1, m[1]};
            slv_tx = 8'h3c ^ 8'(m * 17);
            repeat (4) @(negedge mclk_i);
            check(8'(sck_o), 8'(cpol_i));
            check(8'(cs_o), 8'(cs_idle));
            send(8'h96 ^ 8'(m));
            take(d);
            check(d, slv_tx);
            check(slv_rx, 8'h96 ^ 8'(m));
            check(8'(cs_o), 8'(cs_idle));
            $display("mode test %0d done", m);
        end
    endtask : t_modes
    task automatic t_stall();
        logic [7:0] d;
        {cpol_i, cpha_i, cs_sel_i, cs_en_i, cs_active_high_i} = 6'b000100;
        slv_tx = 8'hc3;
        repeat (4) @(negedge mclk_i);
        send(8'h5a);
        cs_en_i = 1;
        repeat (100) @(negedge mclk_i);
        check(8'(cs_o), 8'h0f);
        send(8'h81);
        repeat (2) @(negedge mclk_i);
        for (int n = 0; n < 15000 && busy_o !== 1'b0; n++) @(negedge mclk_i);
        check(8'(busy_o), 8'h00);
        repeat (4) @(negedge mclk_i);
        check(8'(tx_ready_o), 8'h00);
        take(d);
        take(d);
        check(d, 8'hc3);
        check(slv_rx, 8'h81);
        check(8'(rx_valid_o), 8'h00);
        $display("stall test done");
    endtask : t_stall
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (8) @(posedge mclk_i);
        @(negedge mclk_i);
        sys_rst_i = 0;
        repeat (2) @(negedge mclk_i);
        check(8'(cs_o), 8'h0f);
        t_modes();
        t_stall();
        stop_test();
    end
    initial begin
        #400000;
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule : spi_master_config_engine_tb
bind spi_master_engine spi_master_engine_chk #(.NUM_CS(NUM_CS), .CS_W(CS_W)) chk (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cpol_i(cpol_i), .cpha_i(cpha_i),
    .cs_en_i(cs_en_i), .cs_sel_i(cs_sel_i), .cs_active_high_i(cs_active_high_i),
    .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o), .busy_o(busy_o),
    .sck_o(sck_o), .mosi_o(mosi_o), .cs_o(cs_o));
